// [src/drfr_pkg.sv]
// constants and types for drive fault reaction selection
// Overview of operation
// [RULE_01] encoder configuration bit 0 says whether an index pulse is used
// [RULE_02] hold a 16-bit offset from encoder index to rotor magnets
// [RULE_03] closed-loop encoder commutation only once an alignment is stored
// [RULE_04] deviation error runs the chosen reaction; all ones is none
// [RULE_05] deviation code 0 switches the power stage off at once, motor free
// [RULE_06] deviation code 1 brakes slow, 2 brakes quick; others reserved
// [RULE_07] limit switch pass sets status warning bit 7, then reacts
// [RULE_08] limit code -1 does nothing, so homing can pass the switch
// [RULE_09] limit code 1 or 2 brakes slow or quick, then switch-on disabled
// [RULE_10] limit code 5 or 6 brakes, then quick-stop active, motor energized
// [RULE_11] after code 5 or 6 the drive may return to operation enabled
// [RULE_12] control bit 2 is left untouched on entering quick-stop active
// [RULE_13] master returns by writing quick-stop bit 0 and then 1 again
// [RULE_14] reserved or unlisted reaction codes act as no reaction
// [RULE_15] each event is seen once and its reaction starts within one cycle; the code reacts only from ST_RUN, deviation outranking limit
package drfr_pkg;
  // ==========================================================================
  // object dictionary indices and subindices
  localparam logic [15:0] IDX_ENCODER   = 16'h33A0;
  localparam logic [15:0] IDX_DEV_CODE  = 16'h3700;
  localparam logic [15:0] IDX_LIM_CODE  = 16'h3701;
  localparam logic [7:0]  SUB_COUNT     = 8'h00;
  localparam logic [7:0]  SUB_CONFIG    = 8'h01;
  localparam logic [7:0]  SUB_ALIGN     = 8'h02;
  // ==========================================================================
  // reset values and fields
  localparam logic [7:0]  ENC_COUNT_RST = 8'h02;
  localparam logic [15:0] ENC_CFG_RST   = 16'h0000;
  localparam logic [15:0] ENC_ALIGN_RST = 16'h0000;
  localparam logic [15:0] DEV_CODE_RST  = 16'hFFFF;
  localparam logic [15:0] LIM_CODE_RST  = 16'hFFFF;
  localparam int          CFG_INDEX_BIT = 0;
  // ==========================================================================
  // reaction codes
  localparam logic [15:0] CODE_NONE     = 16'hFFFF;
  localparam logic [15:0] CODE_FREE     = 16'h0000;
  localparam logic [15:0] CODE_SLOW     = 16'h0001;
  localparam logic [15:0] CODE_QUICK    = 16'h0002;
  localparam logic [15:0] CODE_SLOW_QSA = 16'h0005;
  localparam logic [15:0] CODE_QUICK_QSA = 16'h0006;
  // ==========================================================================
  // reaction state machine
  typedef enum logic [2:0] {
    ST_RUN, ST_BRAKE, ST_FREE, ST_SOD, ST_QSA
  } drfr_state_e;
endpackage : drfr_pkg

// [src/drfr_top.sv]
// fault reaction selection and incremental encoder configuration
`timescale 1ns/1ps
module drfr_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // object dictionary access from the fieldbus side
  input  wire logic        od_req,
  input  wire logic        od_wr,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subidx,
  input  wire logic [15:0] od_wdata,
  output logic             od_ack,
  output logic             od_abort,
  output logic      [15:0] od_rdata,
  // fault events
  input  wire logic        dev_error,
  input  wire logic        limit_pin,
  // drive state machine side
  input  wire logic        ctrl_quick_stop,
  input  wire logic        ramp_done,
  input  wire logic        fault_reset,
  output logic             stage_off,
  output logic             ramp_slow,
  output logic             ramp_quick,
  output logic             state_sod,
  output logic             state_qsa,
  output logic             op_resume,
  output logic             status_warning,
  // encoder setup
  output logic             index_used,
  output logic             closed_loop_ok,
  output logic      [15:0] align_offset
);
  // ==========================================================================
  // object dictionary registers
  logic [15:0] cfg_q, cfg_d, align_q, align_d, dev_q, dev_d, lim_q, lim_d;
  logic        aval_q, aval_d, ack_q, ack_d, abort_q, abort_d;
  logic [15:0] rdata_q, rdata_d;
  logic        hit_enc, hit_dev, hit_lim;

  // decode one request per cycle; answer comes on the next edge
  always_comb begin
    hit_enc  = od_index == drfr_pkg::IDX_ENCODER;
    hit_dev  = od_index == drfr_pkg::IDX_DEV_CODE
               && od_subidx == drfr_pkg::SUB_COUNT;
    hit_lim  = od_index == drfr_pkg::IDX_LIM_CODE
               && od_subidx == drfr_pkg::SUB_COUNT;
    cfg_d    = cfg_q;
    align_d  = align_q;
    dev_d    = dev_q;
    lim_d    = lim_q;
    aval_d   = aval_q;
    ack_d    = 1'b0;
    abort_d  = 1'b0;
    rdata_d  = rdata_q;
    if (od_req) begin
      ack_d   = 1'b1;
      abort_d = 1'b1;
      if (hit_enc && od_subidx == drfr_pkg::SUB_COUNT && !od_wr) begin
        abort_d = 1'b0;
        rdata_d = {8'h00, drfr_pkg::ENC_COUNT_RST};
      end else if (hit_enc && od_subidx == drfr_pkg::SUB_CONFIG) begin
        abort_d = 1'b0;
        if (od_wr) cfg_d = od_wdata;                         // [RULE_01]
        rdata_d = od_wr ? od_wdata : cfg_q;
      end else if (hit_enc && od_subidx == drfr_pkg::SUB_ALIGN) begin
        abort_d = 1'b0;
        if (od_wr) begin
          align_d = od_wdata;                                // [RULE_02]
          aval_d  = 1'b1;                                    // [RULE_03]
        end
        rdata_d = od_wr ? od_wdata : align_q;
      end else if (hit_dev) begin
        abort_d = 1'b0;
        if (od_wr) dev_d = od_wdata;                         // [RULE_04]
        rdata_d = od_wr ? od_wdata : dev_q;
      end else if (hit_lim) begin
        abort_d = 1'b0;
        if (od_wr) lim_d = od_wdata;
        rdata_d = od_wr ? od_wdata : lim_q;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q   <= drfr_pkg::ENC_CFG_RST;
      align_q <= drfr_pkg::ENC_ALIGN_RST;
      dev_q   <= drfr_pkg::DEV_CODE_RST;
      lim_q   <= drfr_pkg::LIM_CODE_RST;
      aval_q  <= 1'b0;
      ack_q   <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      cfg_q   <= cfg_d;
      align_q <= align_d;
      dev_q   <= dev_d;
      lim_q   <= lim_d;
      aval_q  <= aval_d;
      ack_q   <= ack_d;
      abort_q <= abort_d;
      rdata_q <= rdata_d;
    end
  end

  assign od_ack         = ack_q;
  assign od_abort       = abort_q;
  assign od_rdata       = rdata_q;
  assign index_used     = cfg_q[drfr_pkg::CFG_INDEX_BIT];    // [RULE_01]
  assign align_offset   = align_q;
  // an all-zero offset is a legal angle, so presence is tracked apart
  assign closed_loop_ok = aval_q;                            // [RULE_03]

  // ==========================================================================
  // event capture
  logic s1_q, s2_q, s3_q, lim_lvl_q, lim_lvl_d, devp_q;
  logic lim_rise, dev_rise;

  // limit pin is asynchronous; a change counts once stages two and three agree
  always_comb begin
    lim_lvl_d = (s2_q == s3_q) ? s3_q : lim_lvl_q;
    lim_rise  = (s2_q == s3_q) && s3_q && !lim_lvl_q;        // [RULE_15]
    dev_rise  = dev_error && !devp_q;                        // [RULE_15]
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      lim_lvl_q <= 1'b0;
      devp_q    <= 1'b0;
    end else begin
      s1_q      <= limit_pin;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      lim_lvl_q <= lim_lvl_d;
      devp_q    <= dev_error;
    end
  end

  // ==========================================================================
  // reaction state machine
  drfr_pkg::drfr_state_e st_q, st_d;
  logic quick_q, quick_d, toqsa_q, toqsa_d, warn_q, warn_d;
  logic qslow_q, qslow_d, resume;
  logic dev_free, dev_slow, dev_quick, lim_brake, lim_quick, lim_qsa;

  // unknown codes fall through to no reaction, never to a switch-off
  always_comb begin
    dev_free  = dev_q == drfr_pkg::CODE_FREE;                // [RULE_05]
    dev_slow  = dev_q == drfr_pkg::CODE_SLOW;                // [RULE_06]
    dev_quick = dev_q == drfr_pkg::CODE_QUICK;               // [RULE_06]
    lim_qsa   = lim_q == drfr_pkg::CODE_SLOW_QSA
                || lim_q == drfr_pkg::CODE_QUICK_QSA;        // [RULE_10]
    lim_quick = lim_q == drfr_pkg::CODE_QUICK
                || lim_q == drfr_pkg::CODE_QUICK_QSA;
    lim_brake = lim_qsa || lim_q == drfr_pkg::CODE_SLOW
                || lim_quick;                      // [RULE_08] [RULE_14]
  end

  // events are taken only while running; deviation outranks limit
  always_comb begin
    st_d    = st_q;
    quick_d = quick_q;
    toqsa_d = toqsa_q;
    qslow_d = qslow_q;
    resume  = 1'b0;
    case (st_q)
      drfr_pkg::ST_RUN: begin
        if (dev_rise && dev_free) begin
          st_d = drfr_pkg::ST_FREE;                          // [RULE_05]
        end else if (dev_rise && (dev_slow || dev_quick)) begin
          st_d    = drfr_pkg::ST_BRAKE;                      // [RULE_04]
          quick_d = dev_quick;
          toqsa_d = 1'b0;
        end else if (lim_rise && lim_brake) begin
          st_d    = drfr_pkg::ST_BRAKE;                      // [RULE_09]
          quick_d = lim_quick;
          toqsa_d = lim_qsa;                                 // [RULE_10]
        end
      end
      drfr_pkg::ST_BRAKE: begin
        if (ramp_done) begin
          st_d    = toqsa_q ? drfr_pkg::ST_QSA : drfr_pkg::ST_SOD;
          qslow_d = 1'b0;
        end
      end
      drfr_pkg::ST_FREE, drfr_pkg::ST_SOD: begin
        if (fault_reset) st_d = drfr_pkg::ST_RUN;
      end
      drfr_pkg::ST_QSA: begin
        // the control bit is only watched, never rewritten here [RULE_12]
        if (!ctrl_quick_stop) qslow_d = 1'b1;
        if (qslow_q && ctrl_quick_stop) begin
          st_d   = drfr_pkg::ST_RUN;                         // [RULE_11]
          resume = 1'b1;                                     // [RULE_13]
        end
      end
      default: st_d = drfr_pkg::ST_RUN;
    endcase
    // set wins over clear
    warn_d = lim_rise || (warn_q && !fault_reset && !resume); // [RULE_07]
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q    <= drfr_pkg::ST_RUN;
      quick_q <= 1'b0;
      toqsa_q <= 1'b0;
      qslow_q <= 1'b0;
      warn_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      quick_q <= quick_d;
      toqsa_q <= toqsa_d;
      qslow_q <= qslow_d;
      warn_q  <= warn_d;
    end
  end

  // outputs decoded from the state register and quick_q, op_resume and status_warning aside (resume, warn_q); qsa keeps the stage energized
  assign stage_off      = st_q == drfr_pkg::ST_FREE
                          || st_q == drfr_pkg::ST_SOD;
  assign ramp_slow      = st_q == drfr_pkg::ST_BRAKE && !quick_q;
  assign ramp_quick     = st_q == drfr_pkg::ST_BRAKE && quick_q;
  assign state_sod      = st_q == drfr_pkg::ST_SOD;
  assign state_qsa      = st_q == drfr_pkg::ST_QSA;
  assign op_resume      = resume;
  assign status_warning = warn_q;

  // ==========================================================================
  // checks
  a_free_on_zero: assert property ( // [RULE_05]
    @(posedge mclk) disable iff (rst)
    st_q == drfr_pkg::ST_RUN && dev_rise && dev_free
    |=> stage_off && !ramp_slow)
    else $error("code 0 deviation did not free the stage");
  a_dev_none: assert property ( // [RULE_04]
    @(posedge mclk) disable iff (rst)
    st_q == drfr_pkg::ST_RUN && dev_rise && dev_q == drfr_pkg::CODE_NONE
    && !lim_rise |=> st_q == drfr_pkg::ST_RUN)
    else $error("no-reaction code changed state");
  a_dev_quick: assert property ( // [RULE_06]
    @(posedge mclk) disable iff (rst)
    st_q == drfr_pkg::ST_RUN && dev_rise && dev_quick |=> ramp_quick)
    else $error("code 2 deviation not on quick ramp");
  a_warn_set: assert property ( // [RULE_07]
    @(posedge mclk) disable iff (rst)
    lim_rise |=> status_warning)
    else $error("limit pass did not set warning");
  a_lim_ignore: assert property ( // [RULE_08]
    @(posedge mclk) disable iff (rst)
    st_q == drfr_pkg::ST_RUN && lim_rise && !dev_rise
    && lim_q == drfr_pkg::CODE_NONE |=> st_q == drfr_pkg::ST_RUN)
    else $error("limit code -1 reacted");
  a_lim_sod: assert property ( // [RULE_09]
    @(posedge mclk) disable iff (rst)
    ramp_slow && !toqsa_q && ramp_done |=> state_sod && stage_off)
    else $error("brake did not end in switch-on disabled");
  a_qsa_live: assert property ( // [RULE_10]
    @(posedge mclk) disable iff (rst)
    state_qsa |-> !stage_off && !ramp_slow && !ramp_quick)
    else $error("quick-stop active dropped the stage");
  // the decode above cannot catch a brake that never lands in qsa
  a_qsa_entry: assert property ( // [RULE_10]
    @(posedge mclk) disable iff (rst)
    (ramp_slow || ramp_quick) && toqsa_q && ramp_done |=> state_qsa)
    else $error("brake bound for quick-stop active went elsewhere");
  // a fresh limit pass on the resume edge sets the warning again
  a_qsa_resume: assert property ( // [RULE_13]
    @(posedge mclk) disable iff (rst)
    state_qsa && !ctrl_quick_stop ##1 state_qsa && ctrl_quick_stop
    && !lim_rise |=> st_q == drfr_pkg::ST_RUN && !status_warning)
    else $error("0 then 1 on quick-stop bit did not resume");
  a_align_ok: assert property ( // [RULE_03]
    @(posedge mclk) disable iff (rst)
    od_req && od_wr && hit_enc && od_subidx == drfr_pkg::SUB_ALIGN
    |=> closed_loop_ok && align_offset == $past(od_wdata))
    else $error("alignment write not taken");
endmodule : drfr_top

// [dv/drfr_master.sv]
// fieldbus master model issuing object dictionary accesses
`timescale 1ns/1ps
module drfr_master (
  // clock
  input  wire logic        mclk,
  // access request and control word bit
  output logic             od_req,
  output logic             od_wr,
  output logic      [15:0] od_index,
  output logic      [7:0]  od_subidx,
  output logic      [15:0] od_wdata,
  output logic             ctrl_quick_stop,
  // answer
  input  wire logic        od_ack,
  input  wire logic        od_abort,
  input  wire logic [15:0] od_rdata
);
  // ==========================================================================
  // idle values; quick-stop bit high means drive may run
  initial begin
    od_req = 1'b0;
    od_wr = 1'b0;
    od_index = 16'h0000;
    od_subidx = 8'h00;
    od_wdata = 16'h0000;
    ctrl_quick_stop = 1'b1;
  end

  // ==========================================================================
  // one access; qualifiers are inverted once released so stale data never
  // looks valid
  task automatic access(input logic wr, input logic [15:0] idx,
                        input logic [7:0] sub, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ab,
                        output logic ok);
    int n;
    @(posedge mclk);
    #1;
    od_req = 1'b1;
    od_wr = wr;
    od_index = idx;
    od_subidx = sub;
    od_wdata = wd;
    @(posedge mclk);
    #1;
    od_req = 1'b0;
    od_wr = ~wr;
    od_index = ~idx;
    od_subidx = ~sub;
    od_wdata = ~wd;
    n = 0;
    while (od_ack !== 1'b1 && n < 3) begin
      @(posedge mclk);
      #1;
      n++;
    end
    ok = od_ack;
    rd = od_rdata;
    ab = od_abort;
  endtask : access

  // ==========================================================================
  // leave quick-stop active: bit low, then high again
  task automatic quick_stop_cycle();
    @(posedge mclk);
    #1;
    ctrl_quick_stop = 1'b0;
    @(posedge mclk);
    #1;
    ctrl_quick_stop = 1'b1;
  endtask : quick_stop_cycle
endmodule : drfr_master

// [dv/drfr_tb_top.sv]
// self-checking bench for fault reaction selection
`timescale 1ns/1ps
module drfr_tb_top;
  logic        mclk, rst, od_req, od_wr, od_ack, od_abort, dev_error;
  logic        limit_pin, ctrl_quick_stop, ramp_done, fault_reset;
  logic        stage_off, ramp_slow, ramp_quick, state_sod, state_qsa;
  logic        op_resume, status_warning, index_used, closed_loop_ok;
  logic [15:0] od_index, od_wdata, od_rdata, align_offset;
  logic [7:0]  od_subidx;
  logic [15:0] m_cfg, m_align, m_dev, m_lim;
  logic        m_seen;
  logic [31:0] seed;
  int          failures, checked, cycles;
  logic [15:0] dcodes [6] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0002,
                              16'h0003, 16'h7FFF};
  logic [15:0] lcodes [7] = '{16'hFFFF, 16'h0001, 16'h0002, 16'h0005,
                              16'h0006, 16'h0003, 16'h0000};

  drfr_top dut (.mclk(mclk), .rst(rst), .od_req(od_req), .od_wr(od_wr),
    .od_index(od_index), .od_subidx(od_subidx), .od_wdata(od_wdata),
    .od_ack(od_ack), .od_abort(od_abort), .od_rdata(od_rdata),
    .dev_error(dev_error), .limit_pin(limit_pin),
    .ctrl_quick_stop(ctrl_quick_stop), .ramp_done(ramp_done),
    .fault_reset(fault_reset), .stage_off(stage_off),
    .ramp_slow(ramp_slow), .ramp_quick(ramp_quick), .state_sod(state_sod),
    .state_qsa(state_qsa), .op_resume(op_resume),
    .status_warning(status_warning), .index_used(index_used),
    .closed_loop_ok(closed_loop_ok), .align_offset(align_offset));

  drfr_master mst (.mclk(mclk), .od_req(od_req), .od_wr(od_wr),
    .od_index(od_index), .od_subidx(od_subidx), .od_wdata(od_wdata),
    .ctrl_quick_stop(ctrl_quick_stop), .od_ack(od_ack),
    .od_abort(od_abort), .od_rdata(od_rdata));

  // ==========================================================================
  // clock, 25 ns period, and a hang limit
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  // ==========================================================================
  // comparison and helpers
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    xs = r ^ (r << 5);
  endfunction : xs

  // access through the master, model decides answer and stored state
  task automatic od(input logic wr, input logic [15:0] idx,
                    input logic [7:0] sub, input logic [15:0] wd);
    logic [15:0] rd, exp;
    logic        ab, ok, eab;
    eab = 1'b0;
    exp = 16'h0002;
    case ({idx, sub})
      {drfr_pkg::IDX_ENCODER, drfr_pkg::SUB_COUNT}: eab = wr;
      {drfr_pkg::IDX_ENCODER, drfr_pkg::SUB_CONFIG}: begin
        if (wr) m_cfg = wd;
        exp = m_cfg;
      end
      {drfr_pkg::IDX_ENCODER, drfr_pkg::SUB_ALIGN}: begin
        if (wr) m_seen = 1'b1;
        if (wr) m_align = wd;
        exp = m_align;
      end
      {drfr_pkg::IDX_DEV_CODE, drfr_pkg::SUB_COUNT}: begin
        if (wr) m_dev = wd;
        exp = m_dev;
      end
      {drfr_pkg::IDX_LIM_CODE, drfr_pkg::SUB_COUNT}: begin
        if (wr) m_lim = wd;
        exp = m_lim;
      end
      default: eab = 1'b1;
    endcase
    mst.access(wr, idx, sub, wd, rd, ab, ok);
    chk_bit(ok, 1'b1);
    chk_bit(ab, eab);
    if (!eab) chk_word(rd, exp);
    chk_bit(index_used, m_cfg[0]);
    chk_word(align_offset, m_align);
    chk_bit(closed_loop_ok, m_seen);
  endtask : od

  // raise one event with a given code and follow the reaction to its end
  task automatic react(input logic lim, input logic [15:0] c);
    int   k;
    logic qsa;
    k = (!lim && c == 16'h0000) ? 1 : 0;
    if (c == 16'h0001 || (lim && c == 16'h0005)) k = 2;
    if (c == 16'h0002 || (lim && c == 16'h0006)) k = 3;
    qsa = lim && (c == 16'h0005 || c == 16'h0006);
    od(1'b1, lim ? drfr_pkg::IDX_LIM_CODE : drfr_pkg::IDX_DEV_CODE,
       8'h00, c);
    if (lim) limit_pin = 1'b1;
    else dev_error = 1'b1;
    repeat (lim ? 6 : 3) @(posedge mclk);
    #1;
    chk_bit(stage_off, k == 1);
    chk_bit(ramp_slow, k == 2);
    chk_bit(ramp_quick, k == 3);
    chk_bit(status_warning, lim);
    ramp_done = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    ramp_done = 1'b0;
    chk_bit(state_qsa, qsa);
    chk_bit(state_sod, k > 1 && !qsa);
    chk_bit(stage_off, k == 1 || (k > 1 && !qsa));
    if (qsa) begin
      mst.quick_stop_cycle();
      #1;
      chk_bit(op_resume, 1'b1);
    end else begin
      fault_reset = 1'b1;
      @(posedge mclk);
      #1;
      fault_reset = 1'b0;
    end
    // event input still high here: a second reaction would be a repeat
    repeat (3) @(posedge mclk);
    #1;
    chk_bit(ramp_slow | ramp_quick | state_sod | state_qsa, 1'b0);
    chk_bit(status_warning, 1'b0);
    dev_error = 1'b0;
    limit_pin = 1'b0;
  endtask : react

  // closing report
  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // main sequence
  initial begin
    {dev_error, limit_pin, ramp_done, fault_reset, m_seen} = 5'h00;
    {m_cfg, m_align} = 32'h0000_0000;
    {m_dev, m_lim} = 32'hFFFF_FFFF;
    seed = 32'h5C32EA0C;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 3; i++) od(1'b0, drfr_pkg::IDX_ENCODER, i[7:0], 16'h0);
    od(1'b0, drfr_pkg::IDX_DEV_CODE, 8'h00, 16'h0000);
    od(1'b0, drfr_pkg::IDX_LIM_CODE, 8'h00, 16'h0000);
    od(1'b1, drfr_pkg::IDX_ENCODER, 8'h00, 16'h0005);
    od(1'b1, drfr_pkg::IDX_DEV_CODE, 8'h01, 16'h0001);
    od(1'b0, 16'h4012, 8'h00, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      od(1'b1, drfr_pkg::IDX_ENCODER, {7'h00, ~i[0]} + 8'h01, seed[15:0]);
      od(1'b0, drfr_pkg::IDX_ENCODER, {7'h00, ~i[0]} + 8'h01, 16'h0000);
    end
    foreach (dcodes[i]) react(1'b0, dcodes[i]);
    foreach (lcodes[i]) react(1'b1, lcodes[i]);
    print_verdict();
  end
endmodule : drfr_tb_top
